// ==== design/cmp_bus_if.sv ====
// operands and result of the threshold comparator
`timescale 1ns/1ps
`default_nettype none
interface cmp_bus_if;
  logic [31:0] liveValue;
  logic [31:0] threshold;
  logic [2:0] op;
  logic hit;
  modport ctrl (output liveValue, output threshold, output op, input hit);
  modport cmp (input liveValue, input threshold, input op, output hit);
endinterface : cmp_bus_if
`default_nettype wire

// ==== design/seq_wait_map.svh ====
// constants for the sequence wait unit
`ifndef SEQ_WAIT_MAP_SVH
`define SEQ_WAIT_MAP_SVH
`define OP_WAIT_BELOW_UNSIGNED 3'h1
`define OP_WAIT_BELOW_SIGNED 3'h2
`define OP_WAIT_ABOVE_UNSIGNED 3'h3
`define OP_WAIT_ABOVE_SIGNED 3'h4
`define OP_WAIT_AXES_IDLE 3'h5
`define OP_WAIT_MOTION_END 3'h6
`define MASTER_AXIS 5'h00
`define OP_CODE_NONE 3'h0
`define SEL_NONE 8'h00
`define SIGN_BIT 31
`define ZERO32 32'h00000000
`define REG_SEL_W 8
`endif

// ==== design/seq_wait_pkg.sv ====
// types for the sequence wait unit
`default_nettype none
package seq_wait_pkg;
  typedef enum logic [2:0]
  {
    OP_NONE = 3'h0,
    OP_BELOW_U = 3'h1,
    OP_BELOW_S = 3'h2,
    OP_ABOVE_U = 3'h3,
    OP_ABOVE_S = 3'h4,
    OP_AXES_IDLE = 3'h5,
    OP_MOTION_END = 3'h6
  } wait_op_t;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_CMP = 2'h1,
    ST_AXES = 2'h2,
    ST_MOTION = 2'h3
  } wait_state_t;
endpackage : seq_wait_pkg
`default_nettype wire

// ==== design/seq_wait_unit.sv ====
// sequence wait unit: compare waits, motion wait and axes idle wait
// Contract
// - unsigned below wait stalls until register is less than threshold, then resumes.
// - signed below wait: same as with signed comparison.
// - unsigned above wait stalls until register exceeds threshold, then resumes.
// - signed above wait: same as with signed comparison.
// - unmet condition keeps the wait forever; no timeout, no error.
// - condition true at start completes the command without extra wait.
// - threshold captured once at command start; later source changes ignored.
// - any parameter, monitoring or user variable register may be tested.
// - axis reports busy during any wait and accepts nothing else.
// - master holds until no selected axis reports busy.
// - idle operand is 32-bit mask, bit n selects axis n.
// - dual-axis variants reject the idle wait command.
`timescale 1ns/1ps
`default_nettype none
`include "seq_wait_map.svh"
module seq_wait_unit
#(
  parameter bit DUAL_AXIS = 1'b0
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmdValid,
  input wire logic [2:0] cmdOp,
  input wire logic [4:0] cmdAxis,
  input wire logic [7:0] cmdRegSel,
  input wire logic [31:0] cmdOperand,
  output logic [7:0] regSel,
  input wire logic [31:0] regValue,
  input wire logic motionActive,
  input wire logic [31:0] axisBusyPin,
  output logic cmdDone,
  output logic cmdReject,
  output logic busy
);
  logic [31:0] busyMeta_r;
  logic [31:0] busySync_r;
  logic [31:0] threshold_r;
  logic [31:0] mask_r;
  logic [2:0] op_r;
  logic [7:0] regSel_r;
  logic done_r;
  logic reject_r;
  logic busy_r;
  logic cmpHit;
  logic startHit;
  logic accept;
  logic isCmp;
  logic axesFree;
  logic refuse;
  seq_wait_pkg::wait_state_t state_r;
  seq_wait_pkg::wait_state_t state_nxt;
  cmp_bus_if cbus();
  cmp_bus_if startBus();

  assign regSel = regSel_r;
  assign cmdDone = done_r;
  assign cmdReject = reject_r;
  assign busy = busy_r;

  // axis busy lines come from other controllers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busyMeta_r <= `ZERO32;
      busySync_r <= `ZERO32;
    end
    else
    begin
      busyMeta_r <= axisBusyPin;
      busySync_r <= busyMeta_r;
    end
  end

  assign isCmp = (cmdOp == `OP_WAIT_BELOW_UNSIGNED) || (cmdOp == `OP_WAIT_BELOW_SIGNED)
    || (cmdOp == `OP_WAIT_ABOVE_UNSIGNED) || (cmdOp == `OP_WAIT_ABOVE_SIGNED);
  assign accept = cmdValid && (state_r == seq_wait_pkg::ST_IDLE);
  assign axesFree = ((busySync_r & mask_r) == `ZERO32);
  // idle wait refused on dual-axis parts or other axes
  assign refuse = accept && (cmdOp == `OP_WAIT_AXES_IDLE) && (DUAL_AXIS || (cmdAxis != `MASTER_AXIS));

  // live compare during the wait
  // live register each cycle
  assign cbus.liveValue = regValue;
  assign cbus.threshold = threshold_r;
  assign cbus.op = op_r;
  assign cmpHit = cbus.hit;
  wait_compare uCmp
  (
    .bus(cbus)
  );

  // compare at command start with the fresh operand
  // immediate completion check
  assign startBus.liveValue = regValue;
  assign startBus.threshold = cmdOperand;
  assign startBus.op = cmdOp;
  assign startHit = startBus.hit;
  wait_compare uStartCmp
  (
    .bus(startBus)
  );

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      seq_wait_pkg::ST_IDLE:
      begin
        if (accept && isCmp && !startHit)
          state_nxt = seq_wait_pkg::ST_CMP;
        // dual-axis parts do not wait for axes
        else if (accept && (cmdOp == `OP_WAIT_AXES_IDLE) && !DUAL_AXIS && (cmdAxis == `MASTER_AXIS))
          state_nxt = seq_wait_pkg::ST_AXES;
        else if (accept && (cmdOp == `OP_WAIT_MOTION_END) && motionActive)
          state_nxt = seq_wait_pkg::ST_MOTION;
      end
      seq_wait_pkg::ST_CMP:
        if (cmpHit)
          state_nxt = seq_wait_pkg::ST_IDLE;
      seq_wait_pkg::ST_AXES:
        if (axesFree)
          state_nxt = seq_wait_pkg::ST_IDLE;
      seq_wait_pkg::ST_MOTION:
        if (!motionActive)
          state_nxt = seq_wait_pkg::ST_IDLE;
      default:
        state_nxt = seq_wait_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      state_r <= seq_wait_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // operand capture at command start
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      threshold_r <= `ZERO32;
      mask_r <= `ZERO32;
      op_r <= `OP_CODE_NONE;
      regSel_r <= `SEL_NONE;
    end
    else if (accept)
    begin
      if (isCmp)
        threshold_r <= cmdOperand;
      if (cmdOp == `OP_WAIT_AXES_IDLE)
        mask_r <= cmdOperand;
      op_r <= cmdOp;
      regSel_r <= cmdRegSel;
    end
  end

  // completion pulse; a refused idle wait gives none
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      done_r <= 1'b0;
    else
      done_r <= ((state_r != seq_wait_pkg::ST_IDLE) && (state_nxt == seq_wait_pkg::ST_IDLE))
        || (accept && !refuse && (state_nxt == seq_wait_pkg::ST_IDLE));
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      reject_r <= 1'b0;
    else
      reject_r <= refuse;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      busy_r <= 1'b0;
    else
      busy_r <= (state_nxt != seq_wait_pkg::ST_IDLE);
  end

  // checks on the wait behaviour
  a_start_hit_done: assert property (@(posedge core_clk) disable iff (!rstn)
    accept && isCmp && startHit |=> done_r && !busy_r)
    else $error("met compare did not finish at once");

  a_start_wait: assert property (@(posedge core_clk) disable iff (!rstn)
    accept && isCmp && !startHit |=> busy_r && !done_r && state_r == seq_wait_pkg::ST_CMP)
    else $error("unmet compare did not start a wait");

  a_cmp_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_CMP && !cmpHit |=> state_r == seq_wait_pkg::ST_CMP)
    else $error("compare wait ended early");

  a_live_release: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_CMP && cmpHit |=> done_r && state_r == seq_wait_pkg::ST_IDLE)
    else $error("live compare hit not released");

  a_threshold_stable: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_CMP |=> $stable(threshold_r))
    else $error("threshold changed during wait");

  a_threshold_capture: assert property (@(posedge core_clk) disable iff (!rstn)
    accept && isCmp |=> threshold_r == $past(cmdOperand))
    else $error("threshold not taken at start");

  a_regsel_capture: assert property (@(posedge core_clk) disable iff (!rstn)
    accept |=> regSel_r == $past(cmdRegSel))
    else $error("register selector not taken");

  a_below_unsigned: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_CMP && op_r == `OP_WAIT_BELOW_UNSIGNED && regValue < threshold_r
    |=> done_r && state_r == seq_wait_pkg::ST_IDLE)
    else $error("unsigned below wait missed");

  a_below_signed: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_CMP && op_r == `OP_WAIT_BELOW_SIGNED
    && $signed(regValue) < $signed(threshold_r) |=> done_r)
    else $error("signed below wait missed");

  a_above_unsigned: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_CMP && op_r == `OP_WAIT_ABOVE_UNSIGNED && regValue > threshold_r
    |=> done_r && state_r == seq_wait_pkg::ST_IDLE)
    else $error("unsigned above wait missed");

  a_above_signed: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_CMP && op_r == `OP_WAIT_ABOVE_SIGNED
    && $signed(regValue) > $signed(threshold_r) |=> done_r)
    else $error("signed above wait missed");

  a_equal_waits: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_CMP && regValue == threshold_r |=> state_r == seq_wait_pkg::ST_CMP)
    else $error("equality ended a compare wait");

  a_axes_release: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_AXES && ((busySync_r & mask_r) == `ZERO32) |=> done_r)
    else $error("axes idle wait not released");

  a_axes_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_AXES && ((busySync_r & mask_r) != `ZERO32) |=> state_r == seq_wait_pkg::ST_AXES && !done_r)
    else $error("axes idle wait ended while busy");

  a_master_accept: assert property (@(posedge core_clk) disable iff (!rstn)
    accept && cmdOp == `OP_WAIT_AXES_IDLE && cmdAxis == `MASTER_AXIS && !DUAL_AXIS |=> busy_r && !reject_r)
    else $error("master idle wait not started");

  a_mask_capture: assert property (@(posedge core_clk) disable iff (!rstn)
    accept && cmdOp == `OP_WAIT_AXES_IDLE |=> mask_r == $past(cmdOperand))
    else $error("axis mask not taken");

  a_reject_master: assert property (@(posedge core_clk) disable iff (!rstn)
    accept && cmdOp == `OP_WAIT_AXES_IDLE && cmdAxis != `MASTER_AXIS |=> reject_r && !done_r && !busy_r)
    else $error("idle wait off master not refused");

  a_dual_reject: assert property (@(posedge core_clk) disable iff (!rstn)
    accept && cmdOp == `OP_WAIT_AXES_IDLE && DUAL_AXIS |=> reject_r && !busy_r && !done_r)
    else $error("dual axis accepted idle wait");

  a_reject_alone: assert property (@(posedge core_clk) disable iff (!rstn)
    reject_r |-> !done_r && !busy_r)
    else $error("refusal came with done or busy");

  a_busy_wait: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r != seq_wait_pkg::ST_IDLE |-> busy_r)
    else $error("busy low during a wait");

  a_busy_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_IDLE |-> !busy_r)
    else $error("busy high with no wait");

  a_wait_ignores: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r != seq_wait_pkg::ST_IDLE && cmdValid |=> $stable(op_r) && $stable(regSel_r) && $stable(threshold_r))
    else $error("command taken during a wait");

  a_motion_busy: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r == seq_wait_pkg::ST_MOTION && motionActive |=> state_r == seq_wait_pkg::ST_MOTION && busy_r)
    else $error("motion wait ended while moving");

  a_done_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    done_r |-> !busy_r)
    else $error("done while still busy");
endmodule : seq_wait_unit
`default_nettype wire

// ==== design/wait_compare.sv ====
// strict threshold comparator, signed or unsigned
`timescale 1ns/1ps
`default_nettype none
`include "seq_wait_map.svh"
module wait_compare
(
  cmp_bus_if.cmp bus
);
  logic ltU;
  logic gtU;
  logic ltS;
  logic gtS;
  logic [2:0] opCode;
  assign opCode = bus.op;
  assign ltU = bus.liveValue < bus.threshold;
  assign gtU = bus.liveValue > bus.threshold;
  assign ltS = $signed(bus.liveValue) < $signed(bus.threshold);
  assign gtS = $signed(bus.liveValue) > $signed(bus.threshold);
  always_comb
  begin
    case (opCode)
      `OP_WAIT_BELOW_UNSIGNED: bus.hit = ltU;
      `OP_WAIT_BELOW_SIGNED: bus.hit = ltS;
      `OP_WAIT_ABOVE_UNSIGNED: bus.hit = gtU;
      `OP_WAIT_ABOVE_SIGNED: bus.hit = gtS;
      default: bus.hit = 1'b0;
    endcase
  end
endmodule : wait_compare
`default_nettype wire

// ==== dv/axis_chain_model.sv ====
// chained axis controllers driving their busy levels
`timescale 1ns/1ps
`default_nettype none
module axis_chain_model
(
  input wire logic core_clk,
  input wire logic [31:0] startMask,
  input wire logic [7:0] holdCycles,
  output logic [31:0] axisBusyPin
);
  logic [7:0] cnt [32];
  initial
    for (int n = 0; n < 32; n++)
      cnt[n] = 8'h00;
  always @(posedge core_clk)
    for (int n = 0; n < 32; n++)
      if (startMask[n])
        cnt[n] <= holdCycles;
      else if (cnt[n] != 8'h00)
        cnt[n] <= cnt[n] - 8'h01;
  always_comb
    for (int n = 0; n < 32; n++)
      axisBusyPin[n] = (cnt[n] != 8'h00);
endmodule : axis_chain_model
`default_nettype wire

// ==== dv/sequence_wait_on_value_and_axis_idle_tb.sv ====
// bench for the sequence wait unit
`timescale 1ns/1ps
`default_nettype none
module sequence_wait_on_value_and_axis_idle_tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmdValid = 1'b0;
  logic motionActive = 1'b0;
  logic [2:0] cmdOp = 3'h0;
  logic [4:0] cmdAxis = 5'h00;
  logic [7:0] cmdRegSel = 8'h00;
  logic [7:0] holdCycles = 8'h14;
  logic [31:0] cmdOperand = 32'h0;
  logic [31:0] regValue = 32'h0;
  logic [31:0] startMask = 32'h0;
  logic [31:0] axisBusyPin;
  logic [7:0] regSel;
  logic cmdDone, cmdReject, busy;
  logic dualDone, dualReject;
  int nMismatch = 0;
  int cmpCount = 0;
  int k;
  seq_wait_unit seq_wait_unit_i (.core_clk(core_clk), .rstn(rstn), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdAxis(cmdAxis), .cmdRegSel(cmdRegSel), .cmdOperand(cmdOperand), .regSel(regSel), .regValue(regValue),
    .motionActive(motionActive), .axisBusyPin(axisBusyPin), .cmdDone(cmdDone), .cmdReject(cmdReject), .busy(busy));
  seq_wait_unit #(.DUAL_AXIS(1'b1)) seq_wait_unit_dual_i (.core_clk(core_clk), .rstn(rstn), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdAxis(cmdAxis), .cmdRegSel(cmdRegSel), .cmdOperand(cmdOperand), .regSel(),
    .regValue(regValue), .motionActive(motionActive), .axisBusyPin(axisBusyPin), .cmdDone(dualDone),
    .cmdReject(dualReject), .busy());
  axis_chain_model axis_chain_model_i (.core_clk(core_clk), .startMask(startMask), .holdCycles(holdCycles),
    .axisBusyPin(axisBusyPin));
  initial
    forever #50 core_clk = ~core_clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic issue(input logic [2:0] op, input logic [4:0] ax, input logic [31:0] opnd, input logic [7:0] sel);
    @(negedge core_clk);
    cmdValid = 1'b1;
    cmdOp = op;
    cmdAxis = ax;
    cmdOperand = opnd;
    cmdRegSel = sel;
    @(negedge core_clk);
    cmdValid = 1'b0;
  endtask : issue
  task automatic wait_end(input int lim);
    k = 0;
    while (cmdDone !== 1'b1 && cmdReject !== 1'b1 && k < lim)
    begin
      @(negedge core_clk);
      k++;
    end
  endtask : wait_end
  task automatic cmp_case(input logic [2:0] op, input logic [31:0] thr, alt, v0, v1, input logic [7:0] sel);
    regValue = v0;
    issue(op, 5'h00, thr, sel);
    cmdOperand = alt;
    wait_end(6);
    check("pending", k, 6);
    check("busy", busy, 1'b1);
    check("regSel", regSel, sel);
    regValue = v1;
    wait_end(4);
    check("done", cmdDone, 1'b1);
    check("busy end", busy, 1'b0);
    @(negedge core_clk);
  endtask : cmp_case
  task automatic imm_case(input logic [2:0] op, input logic [31:0] thr, v0);
    regValue = v0;
    issue(op, 5'h00, thr, 8'h0B);
    wait_end(2);
    check("immediate", cmdDone, 1'b1);
    check("immediate wait", k, 0);
    check("no wait busy", busy, 1'b0);
    @(negedge core_clk);
  endtask : imm_case
  task automatic idle_case();
    startMask = 32'h00000008;
    @(negedge core_clk);
    startMask = 32'h0;
    issue(3'h5, 5'h00, 32'h00000002, 8'h00);
    check("dual reject", dualReject, 1'b1);
    check("dual no done", dualDone, 1'b0);
    wait_end(5);
    check("unselected", cmdDone, 1'b1);
    @(negedge core_clk);
    startMask = 32'h00000002;
    @(negedge core_clk);
    startMask = 32'h0;
    issue(3'h5, 5'h00, 32'h80000002, 8'h00);
    wait_end(40);
    check("idle done", cmdDone, 1'b1);
    check("idle late", k > 14, 1'b1);
    @(negedge core_clk);
    issue(3'h5, 5'h01, 32'h00000002, 8'h00);
    wait_end(3);
    check("reject", cmdReject, 1'b1);
    check("no done", cmdDone, 1'b0);
    @(negedge core_clk);
  endtask : idle_case
  task automatic motion_case();
    motionActive = 1'b1;
    issue(3'h6, 5'h00, 32'h0, 8'h00);
    regValue = 32'h0;
    issue(3'h1, 5'h00, 32'h00000010, 8'h00);
    wait_end(8);
    check("motion hold", k, 8);
    motionActive = 1'b0;
    wait_end(4);
    check("motion done", cmdDone, 1'b1);
    @(negedge core_clk);
    wait_end(3);
    check("ignored", k, 3);
  endtask : motion_case
  task automatic final_report();
    if (nMismatch == 0 && cmpCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    #200000;
    nMismatch++;
    final_report();
  end
  initial
  begin
    repeat (12) @(negedge core_clk);
    check("reset busy", busy, 1'b0);
    rstn = 1'b1;
    cmp_case(3'h1, 32'h0000000A, 32'h00000014, 32'h0000000A, 32'h00000009, 8'h21);
    cmp_case(3'h2, 32'h00000000, 32'h0000000A, 32'h00000005, 32'hFFFFFFFF, 8'h42);
    cmp_case(3'h3, 32'hFFFFFFF0, 32'h00000000, 32'h00000005, 32'hFFFFFFFF, 8'h83);
    cmp_case(3'h4, 32'hFFFFFFF0, 32'hFFFFFF00, 32'hFFFFFFE0, 32'h00000001, 8'h0B);
    cmp_case(3'h3, 32'h00000007, 32'h00000000, 32'h00000007, 32'h00000008, 8'h0C);
    imm_case(3'h1, 32'h0000000A, 32'h00000003);
    imm_case(3'h4, 32'hFFFFFFF0, 32'h00000000);
    idle_case();
    motion_case();
    final_report();
  end
endmodule : sequence_wait_on_value_and_axis_idle_tb
`default_nettype wire
